// ===== core/cmbf_top.sv
// Mode control and transceiver bias state machine
`default_nettype none
module cmbf_top
   import cmbf_pkg::*;
#(
   parameter int FILTER_CYC = cmbf_pkg::WAKE_FILTER_CYC,
   parameter int WAKE_TIMEOUT_CYC = cmbf_pkg::WAKE_PATTERN_TIMEOUT_CYC,
   parameter int SILENCE_CYC = cmbf_pkg::BUS_SILENCE_TIMEOUT_CYC,
   parameter int INACTIVE_CYC = cmbf_pkg::INACTIVE_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Host side
   input wire cmbf_pkg::cmbf_req_t mode_req_i,
   input wire logic mode_req_valid_i,
   input wire logic txd_i,
   input wire logic ext_reset_low_i,
   // Bus and wake pin
   input wire logic bus_dominant_i,
   input wire logic wake_pin_i,
   // Comparators
   input wire logic thermal_shutdown_rising_i,
   input wire logic thermal_shutdown_falling_i,
   input wire logic regulator_overvoltage_rising_i,
   input wire logic regulator_overvoltage_falling_i,
   input wire logic supply_undervoltage_falling_i,
   input wire logic supply_undervoltage_rising_i,
   // Mode outputs
   output cmbf_pkg::cmbf_mode_t mode_o,
   output cmbf_pkg::cmbf_bias_t bias_o,
   output logic reset_output_low_o,
   output logic power_inhibit_output_o,
   output logic regulator_output_o,
   // Transceiver control
   output logic tx_enable_o,
   output logic rx_enable_o,
   output logic bias_mid_o,
   output logic bias_from_regulator_o,
   output logic bus_float_o,
   output logic txd_block_o,
   // Receive data pin
   output logic rxd_o,
   output logic rxd_oe_n_o,
   // Events
   output logic local_wake_event_o
);
   // ----------------------------------------------------------------
   // Comparator synchronisation
   // ----------------------------------------------------------------
   logic [5:0] cmp_sync;
   // Levels used by the transitions
   cmbf_sync #(.W(6)) u_sync (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .d_i({thermal_shutdown_rising_i, thermal_shutdown_falling_i,
            regulator_overvoltage_rising_i, regulator_overvoltage_falling_i,
            supply_undervoltage_falling_i, supply_undervoltage_rising_i}),
      .q_o(cmp_sync)
   );
   wire hot = cmp_sync[5];
   wire cool = !cmp_sync[4];
   wire ov_hi = cmp_sync[3];
   wire ov_low = !cmp_sync[2];
   wire uv_low = cmp_sync[1];
   wire sup_good = !cmp_sync[0];

   // ----------------------------------------------------------------
   // Wake detection
   // ----------------------------------------------------------------
   cmbf_mode_t mode_reg, mode_next;
   cmbf_bias_t bias_reg, bias_next;
   logic wake_prev_reg;
   logic wup;
   logic lp_rx_en;
   logic wake_latch_reg;
   logic txd_low_reg;
   logic [CNT_W-1:0] sil_reg;
   logic [CNT_W-1:0] inact_reg;

   assign lp_rx_en = (mode_reg == CMBF_RESET) ||
      (mode_reg == CMBF_STANDBY) || (mode_reg == CMBF_SLEEP) ||
      (mode_reg == CMBF_FAILSAFE);

   cmbf_wup_det #(
      .FILTER_CYC(FILTER_CYC),
      .TIMEOUT_CYC(WAKE_TIMEOUT_CYC)
   ) u_wup (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .enable_i(lp_rx_en),
      .bus_dominant_i(bus_dominant_i),
      .bus_wake_pattern_o(wup)
   );

   // Either edge, only in sleep and fail-safe, none in normal
   wire lwu_edge = (wake_pin_i != wake_prev_reg);
   wire lwu_en = (mode_reg == CMBF_SLEEP) || (mode_reg == CMBF_FAILSAFE);
   wire local_wake_event = lwu_edge && lwu_en;
   wire wake_any = wup || local_wake_event;

   // ----------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------
   wire sil_done = (sil_reg >= CNT_W'(SILENCE_CYC));
   wire inact_done = (inact_reg >= CNT_W'(INACTIVE_CYC));
   wire fault = hot || ov_hi;
   wire fault_clear = cool && ov_low;
   wire req_normal = mode_req_valid_i && (mode_req_i == CMBF_REQ_NORMAL);

   // ----------------------------------------------------------------
   // Device mode
   // ----------------------------------------------------------------
   always_comb begin
      mode_next = mode_reg;
      if (ext_reset_low_i) begin
         mode_next = CMBF_RESET;
      end else if (fault && mode_reg != CMBF_SLEEP &&
                   mode_reg != CMBF_FAILSAFE) begin
         mode_next = CMBF_FAILSAFE;
      end else begin
         case (mode_reg)
            CMBF_FAILSAFE: begin
               if (fault_clear && wake_any)
                  mode_next = CMBF_RESET;
               else if (inact_done)
                  mode_next = CMBF_SLEEP;
            end
            CMBF_SLEEP: begin
               if (wake_any && !fault)
                  mode_next = CMBF_RESET;
            end
            CMBF_RESET, CMBF_NORMAL, CMBF_SILENT, CMBF_STANDBY: begin
               if (mode_req_valid_i) begin
                  case (mode_req_i)
                     CMBF_REQ_NORMAL: mode_next = CMBF_NORMAL;
                     CMBF_REQ_SILENT: mode_next = CMBF_SILENT;
                     CMBF_REQ_STANDBY: mode_next = CMBF_STANDBY;
                     CMBF_REQ_SLEEP: mode_next = CMBF_SLEEP;
                     default: mode_next = mode_reg;
                  endcase
               end else if (mode_reg == CMBF_STANDBY && inact_done) begin
                  mode_next = CMBF_SLEEP;
               end
            end
            default: mode_next = CMBF_RESET;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Transceiver bias
   // ----------------------------------------------------------------
   wire auto_mode = (mode_next == CMBF_STANDBY) ||
      (mode_next == CMBF_SLEEP) || (mode_next == CMBF_FAILSAFE) ||
      (mode_next == CMBF_RESET);
   wire act_mode = (mode_next == CMBF_NORMAL) ||
      (mode_next == CMBF_SILENT);

   always_comb begin
      bias_next = bias_reg;
      if (hot || uv_low) begin
         bias_next = CMBF_OFF;
      end else begin
         case (bias_reg)
            CMBF_OFF: begin
               if (sup_good && cool)
                  bias_next = CMBF_AUTO_INACTIVE;
            end
            CMBF_AUTO_INACTIVE: begin
               if (act_mode)
                  bias_next = CMBF_ACTIVE;
               else if (wup)
                  bias_next = CMBF_AUTO_ACTIVE;
            end
            CMBF_AUTO_ACTIVE: begin
               if (act_mode)
                  bias_next = CMBF_ACTIVE;
               else if (sil_done)
                  bias_next = CMBF_AUTO_INACTIVE;
            end
            CMBF_ACTIVE: begin
               if (auto_mode)
                  bias_next = CMBF_AUTO_INACTIVE;
            end
            default: bias_next = CMBF_OFF;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State, timers and latches
   // ----------------------------------------------------------------
   wire leave_standby = (mode_reg == CMBF_STANDBY) &&
      (mode_next != CMBF_STANDBY);
   wire inact_run = (mode_reg == CMBF_STANDBY) ||
      (mode_reg == CMBF_FAILSAFE);

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_reg <= CMBF_RESET;
         bias_reg <= CMBF_OFF;
         wake_prev_reg <= 1'b0;
         sil_reg <= '0;
         inact_reg <= '0;
         wake_latch_reg <= 1'b1;
         txd_low_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         bias_reg <= bias_next;
         wake_prev_reg <= wake_pin_i;
         sil_reg <= (bias_reg != CMBF_AUTO_ACTIVE || req_normal) ? '0 :
            (sil_done ? sil_reg : sil_reg + 1'b1);
         inact_reg <= (!inact_run || mode_next != mode_reg) ? '0 :
            (inact_done ? inact_reg : inact_reg + 1'b1);
         // Set wins over the clear in normal and silent
         if (wake_any)
            wake_latch_reg <= 1'b1;
         else if (act_mode)
            wake_latch_reg <= 1'b0;
         // Transmit input held low when standby is left
         if (leave_standby)
            txd_low_reg <= !txd_i;
         else if (bias_reg != CMBF_ACTIVE && bias_next != CMBF_ACTIVE)
            txd_low_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   wire reg_on = (mode_next != CMBF_FAILSAFE) && (mode_next != CMBF_SLEEP);
   wire blk = txd_low_reg || (leave_standby && !txd_i);
   wire active_next = (bias_next == CMBF_ACTIVE);

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_o <= CMBF_RESET;
         bias_o <= CMBF_OFF;
         reset_output_low_o <= 1'b1;
         power_inhibit_output_o <= 1'b0;
         regulator_output_o <= 1'b0;
         tx_enable_o <= 1'b0;
         rx_enable_o <= 1'b0;
         bias_mid_o <= 1'b0;
         bias_from_regulator_o <= 1'b0;
         bus_float_o <= 1'b1;
         txd_block_o <= 1'b0;
         rxd_o <= 1'b1;
         rxd_oe_n_o <= 1'b1;
         local_wake_event_o <= 1'b0;
      end else begin
         mode_o <= mode_next;
         bias_o <= bias_next;
         // Reset and fail-safe hold reset low
         reset_output_low_o <= (mode_next == CMBF_RESET) ||
            (mode_next == CMBF_FAILSAFE);
         power_inhibit_output_o <= reg_on;
         regulator_output_o <= reg_on;
         // Driver only in normal, receiver in normal and silent
         tx_enable_o <= active_next && (mode_next == CMBF_NORMAL) && !blk;
         rx_enable_o <= active_next && !blk;
         bias_mid_o <= (bias_next == CMBF_AUTO_ACTIVE) || active_next;
         bias_from_regulator_o <= active_next;
         bus_float_o <= (bias_next == CMBF_OFF);
         txd_block_o <= active_next && blk;
         // Bus state in active modes, else latched wake
         rxd_o <= act_mode ? !bus_dominant_i : !(wake_latch_reg || wake_any);
         rxd_oe_n_o <= !reg_on;
         local_wake_event_o <= local_wake_event;
      end
   end
endmodule
`default_nettype wire

// ===== pkg/cmbf_pkg.sv
// Constants and types for the CAN mode and bias control block
`default_nettype none
package cmbf_pkg;
   // Clock rate in kHz
   localparam int CLK_KHZ = 125000;
   // Times in microseconds
   localparam int WAKE_FILTER_TIME_US = 1;
   localparam int WAKE_PATTERN_TIMEOUT_US = 1000;
   localparam int BUS_SILENCE_TIMEOUT_US = 1000;
   localparam int INACTIVE_TIMEOUT_US = 100000;
   // Cycle counts: filter is a least time (round up), timeouts longest
   localparam int WAKE_FILTER_CYC =
      (WAKE_FILTER_TIME_US * CLK_KHZ + 999) / 1000;
   localparam int WAKE_PATTERN_TIMEOUT_CYC =
      (WAKE_PATTERN_TIMEOUT_US * CLK_KHZ) / 1000;
   localparam int BUS_SILENCE_TIMEOUT_CYC =
      (BUS_SILENCE_TIMEOUT_US * CLK_KHZ) / 1000;
   localparam int INACTIVE_TIMEOUT_CYC =
      (INACTIVE_TIMEOUT_US * CLK_KHZ) / 1000;
   localparam int CNT_W = 24;
   // Requested operating mode from the host side
   typedef enum logic [1:0] {
      CMBF_REQ_NORMAL = 2'h0,
      CMBF_REQ_SILENT = 2'h1,
      CMBF_REQ_STANDBY = 2'h2,
      CMBF_REQ_SLEEP = 2'h3
   } cmbf_req_t;
   // Device modes
   typedef enum logic [2:0] {
      CMBF_RESET,
      CMBF_FAILSAFE,
      CMBF_NORMAL,
      CMBF_SILENT,
      CMBF_STANDBY,
      CMBF_SLEEP
   } cmbf_mode_t;
   // Transceiver bias states
   typedef enum logic [1:0] {
      CMBF_OFF,
      CMBF_AUTO_INACTIVE,
      CMBF_AUTO_ACTIVE,
      CMBF_ACTIVE
   } cmbf_bias_t;
endpackage
`default_nettype wire

// ===== core/cmbf_sync.sv
// Two-flop synchroniser for comparator levels
`default_nettype none
module cmbf_sync #(
   parameter int W = 3
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Levels
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ===== core/cmbf_wup_det.sv
// Bus wake pattern detector: dominant, recessive, dominant within timeout
`default_nettype none
module cmbf_wup_det
   import cmbf_pkg::*;
#(
   parameter int FILTER_CYC = cmbf_pkg::WAKE_FILTER_CYC,
   parameter int TIMEOUT_CYC = cmbf_pkg::WAKE_PATTERN_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Control and bus
   input wire logic enable_i,
   input wire logic bus_dominant_i,
   // Result
   output logic bus_wake_pattern_o
);
   typedef enum {
      CMBF_W_IDLE,
      CMBF_W_DOM1,
      CMBF_W_REC,
      CMBF_W_DOM2
   } cmbf_wst_t;

   cmbf_wst_t st_reg;
   logic [CNT_W-1:0] filt_reg;
   logic [CNT_W-1:0] tmo_reg;
   logic prev_reg;
   wire filt_done = (filt_reg >= CNT_W'(FILTER_CYC));
   wire tmo_hit = (st_reg != CMBF_W_IDLE) &&
      (tmo_reg >= CNT_W'(TIMEOUT_CYC));
   wire changed = (bus_dominant_i != prev_reg);

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_reg <= CMBF_W_IDLE;
         filt_reg <= '0;
         tmo_reg <= '0;
         prev_reg <= 1'b0;
         bus_wake_pattern_o <= 1'b0;
      end else begin
         prev_reg <= bus_dominant_i;
         bus_wake_pattern_o <= 1'b0;
         filt_reg <= changed ? '0 : (filt_done ? filt_reg : filt_reg + 1'b1);
         tmo_reg <= (st_reg == CMBF_W_IDLE) ? '0 : tmo_reg + 1'b1;
         // Pattern must finish in the timeout
         if (!enable_i || tmo_hit) begin
            st_reg <= CMBF_W_IDLE;
         end else begin
            // Three filtered phases
            case (st_reg)
               CMBF_W_IDLE: begin
                  if (bus_dominant_i && !changed && filt_done)
                     st_reg <= CMBF_W_DOM1;
               end
               CMBF_W_DOM1: begin
                  if (!bus_dominant_i && !changed && filt_done)
                     st_reg <= CMBF_W_REC;
               end
               CMBF_W_REC: begin
                  if (bus_dominant_i && !changed && filt_done)
                     st_reg <= CMBF_W_DOM2;
               end
               CMBF_W_DOM2: begin
                  bus_wake_pattern_o <= 1'b1;
                  st_reg <= CMBF_W_IDLE;
               end
               default: st_reg <= CMBF_W_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/cmbf_top_checker.sv
// Concurrent checks on the mode and bias control ports
`default_nettype none
module cmbf_top_checker
   import cmbf_pkg::*;
#(
   parameter int SILENCE_CYC = 50
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Watched inputs
   input wire cmbf_pkg::cmbf_req_t mode_req_i,
   input wire logic mode_req_valid_i,
   input wire logic txd_i,
   input wire logic ext_reset_low_i,
   input wire logic bus_dominant_i,
   input wire logic wake_pin_i,
   input wire logic thermal_shutdown_rising_i,
   input wire logic supply_undervoltage_falling_i,
   input wire logic supply_undervoltage_rising_i,
   // Watched outputs
   input wire cmbf_pkg::cmbf_mode_t mode_o,
   input wire cmbf_pkg::cmbf_bias_t bias_o,
   input wire logic reset_output_low_o,
   input wire logic power_inhibit_output_o,
   input wire logic regulator_output_o,
   input wire logic tx_enable_o,
   input wire logic rx_enable_o,
   input wire logic bias_mid_o,
   input wire logic bus_float_o,
   input wire logic txd_block_o,
   input wire logic rxd_o,
   input wire logic rxd_oe_n_o,
   input wire logic local_wake_event_o
);
   // ---------------------------------------------
   // Helper: cycles of quiet autonomous bias
   // ---------------------------------------------
   logic [15:0] quiet_cnt_reg;
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         quiet_cnt_reg <= 16'h0000;
      else if (bias_o == CMBF_AUTO_ACTIVE && !bus_dominant_i &&
               !mode_req_valid_i)
         quiet_cnt_reg <= quiet_cnt_reg + 16'h0001;
      else
         quiet_cnt_reg <= 16'h0000;
   end
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!reset_n_i);
   chk_reset_mode_outputs: assert property (
      $stable(mode_o) && mode_o == CMBF_RESET |->
      reset_output_low_o && !tx_enable_o && !rx_enable_o)
      else $error("reset mode outputs wrong");
   chk_failsafe_outputs: assert property (
      $stable(mode_o) && mode_o == CMBF_FAILSAFE |-> reset_output_low_o &&
      !regulator_output_o && !power_inhibit_output_o && !tx_enable_o &&
      !rx_enable_o)
      else $error("fail-safe outputs wrong");
   chk_rxd_undriven: assert property (
      !regulator_output_o |-> rxd_oe_n_o)
      else $error("receive pin driven without regulator");
   chk_hot_entry: assert property (
      (thermal_shutdown_rising_i && !ext_reset_low_i &&
       mode_o != CMBF_SLEEP)[*5] |-> mode_o == CMBF_FAILSAFE)
      else $error("no fail-safe on overtemperature");
   chk_off_state: assert property (
      (thermal_shutdown_rising_i || supply_undervoltage_falling_i)[*5]
      |-> bias_o == CMBF_OFF && bus_float_o)
      else $error("transceiver not off");
   chk_failsafe_exit: assert property (
      $past(mode_o) == CMBF_FAILSAFE && mode_o != CMBF_FAILSAFE |->
      mode_o inside {CMBF_RESET, CMBF_SLEEP})
      else $error("bad fail-safe exit");
   chk_normal_entry: assert property (
      (!supply_undervoltage_falling_i && !supply_undervoltage_rising_i &&
       !thermal_shutdown_rising_i && !ext_reset_low_i)[*3] ##0
      (mode_req_valid_i && mode_req_i == CMBF_REQ_NORMAL &&
       mode_o == CMBF_STANDBY) |=> bias_o == CMBF_ACTIVE)
      else $error("no active bias in normal");
   chk_txd_block: assert property (
      mode_req_valid_i && mode_req_i == CMBF_REQ_NORMAL &&
      mode_o == CMBF_STANDBY |=>
      mode_o != CMBF_NORMAL || txd_block_o == !$past(txd_i))
      else $error("transmit block wrong");
   chk_local_wake: assert property (
      mode_o == CMBF_SLEEP && $changed(wake_pin_i) |=> local_wake_event_o)
      else $error("wake pin edge missed");
   chk_bus_wake_rxd: assert property (
      $past(bias_o) == CMBF_AUTO_INACTIVE && bias_o == CMBF_AUTO_ACTIVE
      |-> bias_mid_o && !rxd_o)
      else $error("bus wake outputs wrong");
   chk_silence_end: assert property (
      int'(quiet_cnt_reg) <= SILENCE_CYC + 3)
      else $error("bias kept past silence time");
endmodule
bind cmbf_top cmbf_top_checker #(.SILENCE_CYC(SILENCE_CYC)) u_checker (.*);
`default_nettype wire

// ===== sim/cmbf_bus_node.sv
// Bus node model that sends wake patterns
`default_nettype none
module cmbf_bus_node (
   // Clock
   input wire logic mclk_i,
   // Bus level, released bus reads recessive
   output logic bus_dominant_o
);
   initial bus_dominant_o = 1'b0;
   // Dominant, recessive, dominant, each len cycles
   task automatic send_wup(input int len);
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk_i);
         bus_dominant_o <= (i != 1);
         repeat (len - 1) @(posedge mclk_i);
      end
      @(posedge mclk_i);
      bus_dominant_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== sim/cmbf_top_tb_top.sv
// Testbench for the mode and bias control block
`default_nettype none
module cmbf_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cmbf_pkg::*;
   localparam int FILT = 4;
   localparam int SIL = 50;
   localparam int INACT = 100;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   cmbf_req_t mode_req_i = CMBF_REQ_STANDBY;
   logic mode_req_valid_i = 1'b0;
   logic txd_i = 1'b1;
   logic ext_reset_low_i = 1'b0;
   logic wake_pin_i = 1'b0;
   logic bus_dominant_i;
   logic thermal_shutdown_rising_i = 1'b0;
   logic thermal_shutdown_falling_i = 1'b0;
   logic regulator_overvoltage_rising_i = 1'b0;
   logic regulator_overvoltage_falling_i = 1'b0;
   logic supply_undervoltage_falling_i = 1'b0;
   logic supply_undervoltage_rising_i = 1'b0;
   cmbf_mode_t mode_o;
   cmbf_bias_t bias_o;
   logic reset_output_low_o, power_inhibit_output_o, regulator_output_o;
   logic tx_enable_o, rx_enable_o, bias_mid_o, bias_from_regulator_o;
   logic bus_float_o, txd_block_o, rxd_o, rxd_oe_n_o, local_wake_event_o;
   int compares = 0;
   int miscompares = 0;
   int pulses = 0;
   always #4 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (local_wake_event_o === 1'b1) pulses++;
   cmbf_top #(
      .FILTER_CYC(FILT),
      .WAKE_TIMEOUT_CYC(200),
      .SILENCE_CYC(SIL),
      .INACTIVE_CYC(INACT)
   ) dut (.*);
   cmbf_bus_node node (.mclk_i(mclk_i), .bus_dominant_o(bus_dominant_i));
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic do_reset;
      @(posedge mclk_i);
      reset_n_i <= 1'b0;
      tick(6);
      @(posedge mclk_i);
      reset_n_i <= 1'b1;
      tick(5);
   endtask
   task automatic req(input cmbf_req_t r);
      @(posedge mclk_i);
      mode_req_i <= r;
      mode_req_valid_i <= 1'b1;
      @(posedge mclk_i);
      mode_req_valid_i <= 1'b0;
      #1;
   endtask
   task automatic wait_bias(input cmbf_bias_t b, input int lim);
      int n;
      n = 0;
      while (bias_o !== b && n < lim) begin
         tick(1);
         n++;
      end
      check("bias wait", bias_o, b);
      if (bias_o !== b)
         finish_test();
   endtask
   task automatic set_cmp(input logic t, input logic o, input logic u);
      @(posedge mclk_i);
      thermal_shutdown_rising_i <= t;
      thermal_shutdown_falling_i <= t;
      regulator_overvoltage_rising_i <= o;
      regulator_overvoltage_falling_i <= o;
      supply_undervoltage_falling_i <= u;
      supply_undervoltage_rising_i <= u;
   endtask
   task automatic toggle_wake;
      @(posedge mclk_i);
      wake_pin_i <= ~wake_pin_i;
      tick(6);
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic sc_power_on;
      do_reset();
      check("mode", mode_o, CMBF_RESET);
      check("rst low", reset_output_low_o, 1'b1);
      check("tx", tx_enable_o, 1'b0);
      check("mid", bias_mid_o, 1'b0);
      check("bias", bias_o, CMBF_AUTO_INACTIVE);
      check("rxd oe", rxd_oe_n_o, 1'b0);
      req(CMBF_REQ_STANDBY);
      @(posedge mclk_i);
      ext_reset_low_i <= 1'b1;
      tick(4);
      check("mode", mode_o, CMBF_RESET);
      @(posedge mclk_i);
      ext_reset_low_i <= 1'b0;
   endtask
   task automatic sc_host_modes;
      int p;
      do_reset();
      req(CMBF_REQ_STANDBY);
      check("bias", bias_o, CMBF_AUTO_INACTIVE);
      check("mid", bias_mid_o, 1'b0);
      req(CMBF_REQ_NORMAL);
      check("bias", bias_o, CMBF_ACTIVE);
      check("tx", tx_enable_o, 1'b1);
      check("reg", bias_from_regulator_o, 1'b1);
      p = pulses;
      toggle_wake();
      check("pulses", 8'(pulses - p), 8'h00);
      req(CMBF_REQ_SILENT);
      check("tx", tx_enable_o, 1'b0);
      check("rx", rx_enable_o, 1'b1);
      check("reg", bias_from_regulator_o, 1'b1);
      req(CMBF_REQ_STANDBY);
      @(posedge mclk_i);
      txd_i <= 1'b0;
      req(CMBF_REQ_NORMAL);
      check("block", txd_block_o, 1'b1);
      check("tx", tx_enable_o, 1'b0);
      @(posedge mclk_i);
      txd_i <= 1'b1;
   endtask
   task automatic sc_local_wake;
      int p;
      do_reset();
      for (int e = 0; e < 2; e++) begin
         req(CMBF_REQ_NORMAL);
         req(CMBF_REQ_SLEEP);
         p = pulses;
         toggle_wake();
         check("pulses", 8'(pulses - p), 8'h01);
         check("asleep", mode_o == CMBF_SLEEP, 1'b0);
      end
   endtask
   task automatic sc_bus_wake;
      do_reset();
      node.send_wup(FILT + 3);
      wait_bias(CMBF_AUTO_ACTIVE, 20);
      check("rxd", rxd_o, 1'b0);
      check("mode", mode_o, CMBF_RESET);
      tick(SIL / 2);
      check("bias", bias_o, CMBF_AUTO_ACTIVE);
      wait_bias(CMBF_AUTO_INACTIVE, SIL);
      req(CMBF_REQ_NORMAL);
      req(CMBF_REQ_SLEEP);
      wait_bias(CMBF_AUTO_INACTIVE, SIL + 10);
      node.send_wup(FILT - 2);
      tick(10);
      check("bias", bias_o, CMBF_AUTO_INACTIVE);
      node.send_wup(110);
      tick(10);
      check("bias", bias_o, CMBF_AUTO_INACTIVE);
      check("mode", mode_o, CMBF_SLEEP);
      node.send_wup(FILT + 3);
      wait_bias(CMBF_AUTO_ACTIVE, 20);
      check("mid", bias_mid_o, 1'b1);
      wait_bias(CMBF_AUTO_INACTIVE, SIL + 10);
      check("mid", bias_mid_o, 1'b0);
   endtask
   task automatic sc_failsafe;
      do_reset();
      req(CMBF_REQ_NORMAL);
      set_cmp(1'b1, 1'b0, 1'b0);
      tick(5);
      check("mode", mode_o, CMBF_FAILSAFE);
      check("reg", regulator_output_o, 1'b0);
      check("inh", power_inhibit_output_o, 1'b0);
      check("rst low", reset_output_low_o, 1'b1);
      check("rxd oe", rxd_oe_n_o, 1'b1);
      check("float", bus_float_o, 1'b1);
      set_cmp(1'b0, 1'b0, 1'b0);
      tick(5);
      check("mode", mode_o, CMBF_FAILSAFE);
      toggle_wake();
      check("mode", mode_o, CMBF_RESET);
      req(CMBF_REQ_NORMAL);
      set_cmp(1'b0, 1'b1, 1'b0);
      tick(5);
      check("mode", mode_o, CMBF_FAILSAFE);
      tick(INACT + 4);
      check("mode", mode_o, CMBF_SLEEP);
      set_cmp(1'b0, 1'b0, 1'b1);
      tick(5);
      check("bias", bias_o, CMBF_OFF);
      set_cmp(1'b0, 1'b0, 1'b0);
      tick(6);
      check("bias", bias_o, CMBF_AUTO_INACTIVE);
   endtask
   initial begin
      sc_power_on();
      sc_host_modes();
      sc_local_wake();
      sc_bus_wake();
      sc_failsafe();
      finish_test();
   end
endmodule
`default_nettype wire
